// file: shared/fru_pkg.sv
// constants and carrier types for the fixed-rate polled serial transceiver
// assumes one processor clock domain; the timer clock arrives as a sampled level
package fru_pkg;

    // line rate derived from the timer clock
    localparam int unsigned TIMER_CLK_HZ  = 12_000_000;
    localparam int unsigned BAUD_RATE     = 9600;
    localparam int unsigned TICKS_PER_BIT = TIMER_CLK_HZ / BAUD_RATE;
    localparam logic [10:0] BIT_LAST      = 11'(TICKS_PER_BIT - 1);
    localparam logic [10:0] BIT_MID       = 11'(TICKS_PER_BIT / 2 - 1);

    // frame layout: start, eight data bits, parity, stop
    localparam logic [3:0] TX_STOP_IDX = 4'ha;
    localparam logic [3:0] RX_STOP_IDX = 4'h9;
    localparam logic       LINE_IDLE   = 1'b0;
    localparam logic       START_LEVEL = 1'b1;
    localparam logic       STOP_LEVEL  = 1'b0;

    // reset values of the status byte, the data bytes and the read word
    localparam logic [7:0]  STATUS_RESET = 8'h06;
    localparam logic [7:0]  DATA_RESET   = 8'h00;
    localparam logic [15:0] WORD_RESET   = 16'h0000;

    typedef enum logic [1:0] {
        FRU_SEL_STATUS = 2'b00,
        FRU_SEL_TX     = 2'b01,
        FRU_SEL_RX     = 2'b10,
        FRU_SEL_NONE   = 2'b11
    } fru_target_e;

    typedef enum logic [1:0] {
        FRU_RX_IDLE  = 2'b00,
        FRU_RX_START = 2'b01,
        FRU_RX_BITS  = 2'b10
    } fru_rx_state_e;

    typedef enum logic {
        FRU_TX_IDLE = 1'b0,
        FRU_TX_SEND = 1'b1
    } fru_tx_state_e;

    typedef struct packed {
        logic rx_error_summary;
        logic overrun_error;
        logic framing_error;
        logic parity_error;
        logic reserved;
        logic tx_buffer_empty;
        logic tx_shifter_empty;
        logic rx_data_ready;
    } fru_status_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        fru_target_e target;
        logic [15:0] wdata;
    } fru_io_req_s;

endpackage : fru_pkg

// file: src/fru_bit_timer.sv
// bit period timer counting rising edges of the timer clock
// assumes timer_clock_in is synchronous to mclk and no faster than half its rate
`timescale 1ns/1ps
`default_nettype none
module fru_bit_timer (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // timing
    input  wire logic tick,
    input  wire logic restart,
    output logic      mid,
    output logic      last
);
    logic [10:0] cnt_ff;
    logic [10:0] nxt_cnt;
    wire         at_last = (cnt_ff == fru_pkg::BIT_LAST);

    assign nxt_cnt = restart ? 11'h000 : (tick ? (at_last ? 11'h000 : cnt_ff + 11'h001) : cnt_ff);
    // not gated by restart: the transmitter decides its reload from last, and
    // gating it here would close a combinational loop through restart
    assign mid     = tick && (cnt_ff == fru_pkg::BIT_MID);
    assign last    = tick && at_last;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cnt_ff <= 11'h000;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule : fru_bit_timer
`default_nettype wire

// file: src/fru_uart.sv
// polled serial transceiver with a three-target instruction port
// assumes io_req and pins are synchronous to mclk; one request per cycle
`timescale 1ns/1ps
`default_nettype none
module fru_uart (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rstn,
    // instruction port
    input  wire fru_pkg::fru_io_req_s io_req,
    output logic [15:0]               io_rdata,
    output logic                      io_rack,
    // timing source
    input  wire logic                 timer_clock_in,
    // serial line
    input  wire logic                 serial_rx_in,
    output logic                      serial_tx_out
);
    function automatic logic odd_fill(input logic [7:0] d);
        odd_fill = ~(^d);
    endfunction : odd_fill

    // timer edge detect; the pin is already synchronous so one flop suffices
    logic tclk_prev_ff;
    wire  tick = timer_clock_in && !tclk_prev_ff;

    // port decode
    wire wr_tx  = io_req.wr && (io_req.target == fru_pkg::FRU_SEL_TX);
    wire rd_rx  = io_req.rd && (io_req.target == fru_pkg::FRU_SEL_RX);
    wire rd_st  = io_req.rd && (io_req.target == fru_pkg::FRU_SEL_STATUS);
    wire rd_any = rd_rx || rd_st;

    // transmit side
    fru_pkg::fru_tx_state_e tx_state_ff, nxt_tx_state;
    logic [7:0]  hold_ff;
    logic        hold_full_ff;
    logic [10:0] tx_sh_ff;
    logic [3:0]  tx_cnt_ff;
    logic        tx_last;
    wire tx_busy      = (tx_state_ff == fru_pkg::FRU_TX_SEND);
    wire tx_frame_end = tx_busy && tx_last && (tx_cnt_ff == fru_pkg::TX_STOP_IDX);
    // reload on the stop bit's last tick, so the next start bit follows with no gap
    wire tx_load      = hold_full_ff && (!tx_busy || tx_frame_end);
    // a write while the buffer is still full is dropped so the queued byte is kept
    wire hold_accept  = wr_tx && !hold_full_ff;

    always_comb begin
        nxt_tx_state = tx_state_ff;
        case (tx_state_ff)
            fru_pkg::FRU_TX_IDLE: if (tx_load) nxt_tx_state = fru_pkg::FRU_TX_SEND;
            fru_pkg::FRU_TX_SEND: if (tx_frame_end && !tx_load) nxt_tx_state = fru_pkg::FRU_TX_IDLE;
            default:              nxt_tx_state = fru_pkg::FRU_TX_IDLE;
        endcase
    end

    // start first, data lsb first, parity, stop; zero fill keeps the idle level
    wire [10:0] tx_frame = {fru_pkg::STOP_LEVEL, odd_fill(hold_ff), hold_ff,
                            fru_pkg::START_LEVEL};
    wire [10:0] nxt_tx_sh = tx_load ? tx_frame :
                            (tx_busy && tx_last) ? {fru_pkg::LINE_IDLE, tx_sh_ff[10:1]} : tx_sh_ff;
    wire [3:0]  nxt_tx_cnt = tx_load ? 4'h0 : (tx_busy && tx_last) ? tx_cnt_ff + 4'h1 : tx_cnt_ff;

    fru_bit_timer u_tx_timer (
        .mclk    (mclk),
        .rstn    (rstn),
        .tick    (tick),
        .restart (tx_load),
        .mid     (),
        .last    (tx_last)
    );

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_state_ff  <= fru_pkg::FRU_TX_IDLE;
            hold_ff      <= fru_pkg::DATA_RESET;
            hold_full_ff <= 1'b0;
            tx_sh_ff     <= 11'h000;
            tx_cnt_ff    <= 4'h0;
            tclk_prev_ff <= 1'b0;
        end else begin
            tx_state_ff  <= nxt_tx_state;
            if (hold_accept) hold_ff <= io_req.wdata[7:0];
            hold_full_ff <= hold_accept || (hold_full_ff && !tx_load);
            tx_sh_ff     <= nxt_tx_sh;
            tx_cnt_ff    <= nxt_tx_cnt;
            tclk_prev_ff <= timer_clock_in;
        end
    end
    // zero fill shifted in behind the stop bit leaves the line at rest
    assign serial_tx_out = tx_sh_ff[0];

    // receive side
    fru_pkg::fru_rx_state_e rx_state_ff, nxt_rx_state;
    logic       rx_in_ff;
    logic [8:0] rx_sh_ff;
    logic [3:0] rx_cnt_ff;
    logic [7:0] rbuf_ff;
    logic       dr_ff, oe_ff, fe_ff, pe_ff;
    logic       rx_mid;
    // the receive timer runs free between frames; a start level realigns it
    wire rx_begin = (rx_state_ff == fru_pkg::FRU_RX_IDLE) && (rx_in_ff == fru_pkg::START_LEVEL);
    wire rx_bit   = (rx_state_ff == fru_pkg::FRU_RX_BITS) && rx_mid;
    wire rx_done  = rx_bit && (rx_cnt_ff == fru_pkg::RX_STOP_IDX);
    wire rx_shift = rx_bit && !rx_done;

    always_comb begin
        nxt_rx_state = rx_state_ff;
        case (rx_state_ff)
            fru_pkg::FRU_RX_IDLE:  if (rx_begin) nxt_rx_state = fru_pkg::FRU_RX_START;
            fru_pkg::FRU_RX_START: begin
                if (rx_mid) begin
                    // a start pulse shorter than half a bit is line noise
                    nxt_rx_state = (rx_in_ff == fru_pkg::START_LEVEL) ?
                                   fru_pkg::FRU_RX_BITS : fru_pkg::FRU_RX_IDLE;
                end
            end
            fru_pkg::FRU_RX_BITS:  if (rx_done) nxt_rx_state = fru_pkg::FRU_RX_IDLE;
            default:               nxt_rx_state = fru_pkg::FRU_RX_IDLE;
        endcase
    end

    fru_bit_timer u_rx_timer (
        .mclk    (mclk),
        .rstn    (rstn),
        .tick    (tick),
        .restart (rx_begin),
        .mid     (rx_mid),
        .last    ()
    );

    // completion in the same cycle as a read wins over the read's clear
    wire rx_clear  = rd_rx && !rx_done;
    wire nxt_dr    = rx_done || (dr_ff && !rd_rx);
    wire par_bad   = ~(^rx_sh_ff);
    // a read in the completing cycle consumed the old character: no overrun
    wire over_hit  = dr_ff && !rd_rx;
    wire [3:0] nxt_rx_cnt = rx_shift ? rx_cnt_ff + 4'h1 :
                            (rx_state_ff == fru_pkg::FRU_RX_START) ? 4'h0 : rx_cnt_ff;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rx_state_ff <= fru_pkg::FRU_RX_IDLE;
            rx_in_ff    <= fru_pkg::LINE_IDLE;
            rx_sh_ff    <= 9'h000;
            rx_cnt_ff   <= 4'h0;
            rbuf_ff     <= fru_pkg::DATA_RESET;
            dr_ff       <= 1'b0;
            oe_ff       <= 1'b0;
            fe_ff       <= 1'b0;
            pe_ff       <= 1'b0;
        end else begin
            rx_state_ff <= nxt_rx_state;
            rx_in_ff    <= serial_rx_in;
            if (rx_shift) rx_sh_ff <= {rx_in_ff, rx_sh_ff[8:1]};
            rx_cnt_ff   <= nxt_rx_cnt;
            if (rx_done) rbuf_ff <= rx_sh_ff[7:0];
            dr_ff       <= nxt_dr;
            if (rx_done) begin
                oe_ff <= over_hit;
                fe_ff <= (rx_in_ff != fru_pkg::STOP_LEVEL);
                pe_ff <= par_bad;
            end else if (rx_clear) begin
                oe_ff <= 1'b0;
                fe_ff <= 1'b0;
                pe_ff <= 1'b0;
            end
        end
    end

    // status byte and read answers
    fru_pkg::fru_status_s status;
    assign status.rx_error_summary = oe_ff || fe_ff || pe_ff;
    assign status.overrun_error    = oe_ff;
    assign status.framing_error    = fe_ff;
    assign status.parity_error     = pe_ff;
    // bit 3 has no function and reads zero
    assign status.reserved         = 1'b0;
    assign status.tx_buffer_empty  = !hold_full_ff;
    assign status.tx_shifter_empty = !tx_busy;
    assign status.rx_data_ready    = dr_ff;

    // the port answers a full word; the upper byte always reads zero
    wire [7:0] rd_byte = rd_rx ? rbuf_ff : status;

    logic [15:0] rdata_ff;
    logic        rack_ff;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= fru_pkg::WORD_RESET;
            rack_ff  <= 1'b0;
        end else begin
            if (rd_any) rdata_ff <= {8'h00, rd_byte};
            rack_ff  <= rd_any;
        end
    end
    assign io_rdata = rdata_ff;
    assign io_rack  = rack_ff;

    // independent count of timer ticks inside each transmitted bit,
    // kept apart from the bit timer so a miscounting timer shows up, checked against the same BIT_LAST
    logic [10:0] chk_ticks_ff;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            chk_ticks_ff <= 11'h000;
        end else if (tx_load || tx_last) begin
            chk_ticks_ff <= 11'h000;
        end else if (tick) begin
            chk_ticks_ff <= chk_ticks_ff + 11'h001;
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    a_line_idle:     assert property (!tx_busy |-> serial_tx_out == fru_pkg::LINE_IDLE)
        else $error("tx line not idle low outside a frame");
    a_start_level:   assert property ($rose(tx_busy) |-> serial_tx_out)
        else $error("frame did not open with start level");
    a_tbe_drop:      assert property (wr_tx && !hold_full_ff |=> !status.tx_buffer_empty)
        else $error("buffer empty flag did not drop after write");
    a_auto_move:     assert property (hold_full_ff && !tx_busy |=>
                                      tx_busy && !hold_full_ff && serial_tx_out)
        else $error("held byte not moved to shifter");
    a_back_to_back:  assert property (tx_frame_end && hold_full_ff |=>
                                      tx_busy && serial_tx_out && tx_cnt_ff == 4'h0)
        else $error("gap between reloaded frames");
    a_err_summary:   assert property (rd_st |=> io_rdata[7] == |io_rdata[6:4])
        else $error("error summary is not the or of errors");
    a_ready_set:     assert property (rx_done |=> dr_ff && rbuf_ff == $past(rx_sh_ff[7:0]))
        else $error("completed character not presented");
    a_read_clear:    assert property (rd_rx && !rx_done |=>
                                      !dr_ff && !oe_ff && !fe_ff && !pe_ff)
        else $error("receive read did not clear flags");
    a_overrun_set:   assert property (rx_done && dr_ff && !rd_rx |=> oe_ff)
        else $error("overrun missed");
    a_upper_zero:    assert property (rd_any |=> io_rack && io_rdata[15:8] == 8'h00)
        else $error("read answer upper byte not zero");
    a_tx_low_byte:   assert property (hold_accept |=> hold_ff == $past(io_req.wdata[7:0]))
        else $error("holding buffer not loaded from low byte");
    a_tx_parity:     assert property (tx_load |=> ^tx_sh_ff[9:1])
        else $error("data plus parity not odd");
    a_tx_stop:       assert property (tx_load |=> tx_sh_ff[10] == 1'b0)
        else $error("stop bit not at rest level");
    a_start_holds:   assert property (tx_busy && tx_cnt_ff == 4'h0 |-> serial_tx_out)
        else $error("start bit not on the line");
    a_idle_shifter:  assert property (!tx_busy |-> tx_sh_ff == 11'h000)
        else $error("shifter not at rest outside a frame");
    a_te_return:     assert property (tx_frame_end && !hold_full_ff |=> !tx_busy)
        else $error("shifter empty flag did not return");
    a_hold_keep:     assert property (hold_full_ff && !tx_load |=> hold_full_ff)
        else $error("buffer empty flag rose before the move");
    a_full_drop:     assert property (wr_tx && hold_full_ff |=> $stable(hold_ff))
        else $error("write to a full buffer overwrote it");
    a_bit_ticks:     assert property (tx_busy && tx_last |->
                                      chk_ticks_ff == fru_pkg::BIT_LAST)
        else $error("bit time is not one bit period of timer ticks");
    a_rx_lsb_first:  assert property (rx_shift |=> rx_sh_ff[8] == $past(rx_in_ff))
        else $error("received bit not shifted in at the top");
    a_frame_flag:    assert property (rx_done |=> fe_ff == $past(rx_in_ff))
        else $error("framing flag does not follow the stop sample");
    a_parity_flag:   assert property (rx_done |=> pe_ff != $past(^rx_sh_ff))
        else $error("parity flag wrong for received character");
    a_oe_clean:      assert property (rx_done && !dr_ff |=> !oe_ff)
        else $error("overrun flagged without a waiting character");
    a_ready_hold:    assert property (dr_ff && !rd_rx |=> dr_ff)
        else $error("data ready dropped without a receive read");
    a_status_quiet:  assert property (rd_st && dr_ff |=> dr_ff)
        else $error("status read cleared data ready");
    a_rack_pulse:    assert property (!rd_any |=> !io_rack)
        else $error("read answer without a read");
    a_rx_byte:       assert property (rd_rx |=> io_rdata[7:0] == $past(rbuf_ff))
        else $error("receive read returned wrong byte");

    // main scenarios: frames both ways, errors and a chained pair
    c_tx_frame:  cover property (tx_frame_end);
    c_rx_char:   cover property (rx_done && !par_bad);
    c_overrun:   cover property (rx_done && dr_ff);
    c_chained:   cover property (tx_frame_end && hold_full_ff);
    c_bad_stop:  cover property (rx_done && rx_in_ff != fru_pkg::STOP_LEVEL);
endmodule : fru_uart
`default_nettype wire

// file: testbench/fru_term_model.sv
// serial terminal model standing on the line side of the transceiver
// assumes bit_cyc mclk cycles make one bit time; drives its line low when idle
`timescale 1ns/1ps
`default_nettype none
module fru_term_model #(
    parameter int BIT_CYC = 2500
) (
    // clock
    input  wire logic mclk,
    // serial line
    input  wire logic line_from_dut,
    output var  logic line_to_dut
);
    logic [7:0] got_byte[$];
    logic       got_ok[$];
    int         got_start[$];
    int         cyc = 0;

    always @(posedge mclk) cyc <= cyc + 1;

    initial line_to_dut = 1'b0;

    // a bad stop is high only for 3/5 of the bit, so its tail stays under the start filter
    task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
        logic [10:0] frm;
        frm = {bad_stop, (~^d) ^ bad_par, d, 1'b1};
        @(posedge mclk);
        #1;
        for (int i = 0; i < 11; i++) begin
            line_to_dut = frm[i];
            repeat ((i == 10 && bad_stop) ? BIT_CYC * 3 / 5 : BIT_CYC) @(posedge mclk);
            #1;
        end
        line_to_dut = 1'b0;
        if (bad_stop) begin
            repeat (BIT_CYC * 2 / 5) @(posedge mclk);
        end
    endtask : send

    initial begin : listen
        logic [9:0] bits;
        forever begin
            // look a step after the edge so the line has settled
            @(posedge mclk);
            #1;
            if (line_from_dut === 1'b1) begin
                got_start.push_back(cyc);
                repeat (BIT_CYC / 2) @(posedge mclk);
                for (int i = 0; i < 10; i++) begin
                    repeat (BIT_CYC) @(posedge mclk);
                    #1;
                    bits[i] = line_from_dut;
                end
                got_byte.push_back(bits[7:0]);
                got_ok.push_back(^bits[8:0] === 1'b1 && bits[9] === 1'b0);
            end
        end
    end
endmodule : fru_term_model
`default_nettype wire

// file: testbench/fru_uart_tb.sv
// self-checking bench for the polled serial transceiver
// assumes the terminal model on the line; timer clock ticks every second mclk
`timescale 1ns/1ps
`default_nettype none
module fru_uart_tb;
    localparam int BIT_CYC = 2 * fru_pkg::TICKS_PER_BIT;
    logic                 mclk = 1'b0;
    logic                 rstn = 1'b0;
    fru_pkg::fru_io_req_s io_req = '0;
    logic [15:0]          io_rdata;
    logic                 io_rack;
    logic                 timer_clock_in = 1'b0;
    logic                 serial_rx_in;
    logic                 serial_tx_out;
    logic [15:0]          rd_val;
    int                   mismatches = 0;
    int                   samples_checked = 0;
    int                   cycles = 0;

    fru_uart dut (
        .mclk           (mclk),
        .rstn           (rstn),
        .io_req         (io_req),
        .io_rdata       (io_rdata),
        .io_rack        (io_rack),
        .timer_clock_in (timer_clock_in),
        .serial_rx_in   (serial_rx_in),
        .serial_tx_out  (serial_tx_out)
    );

    fru_term_model #(.BIT_CYC(BIT_CYC)) term (
        .mclk          (mclk),
        .line_from_dut (serial_tx_out),
        .line_to_dut   (serial_rx_in)
    );

    initial begin
        forever #50 mclk = ~mclk;
    end

    // fastest legal timer clock keeps three frames inside the run budget
    initial begin
        forever begin
            @(posedge mclk);
            #1 timer_clock_in = ~timer_clock_in;
        end
    end

    task automatic summarize();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : summarize

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 95000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic cmp16(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp16

    task automatic cmp1(input string what, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : cmp1

    task automatic io_wr(input logic [15:0] d);
        @(posedge mclk);
        #1 io_req = '{wr: 1'b1, rd: 1'b0, target: fru_pkg::FRU_SEL_TX, wdata: d};
        @(posedge mclk);
        #1 io_req = '0;
    endtask : io_wr

    task automatic io_rd(input fru_pkg::fru_target_e t, output logic [15:0] v);
        @(posedge mclk);
        #1 io_req = '{wr: 1'b0, rd: 1'b1, target: t, wdata: 16'h0000};
        @(posedge mclk);
        #1 io_req = '0;
        cmp1("io_rack", 1'b1, io_rack);
        v = io_rdata;
    endtask : io_rd

    // mask hides the transmit flags while a frame of the other direction runs
    task automatic chk_status(input logic [7:0] exp, input logic [7:0] mask);
        io_rd(fru_pkg::FRU_SEL_STATUS, rd_val);
        cmp16("status", {8'h00, exp}, {rd_val[15:8], rd_val[7:0] & mask});
    endtask : chk_status

    task automatic poll_ready();
        rd_val = 16'h0000;
        for (int i = 0; i < 8 && rd_val[0] !== 1'b1; i++) begin
            io_rd(fru_pkg::FRU_SEL_STATUS, rd_val);
        end
        cmp1("rx_data_ready", 1'b1, rd_val[0]);
    endtask : poll_ready

    initial begin : main
        repeat (2) @(posedge mclk);
        #1 rstn = 1'b1;
        chk_status(8'h06, 8'hff);
        cmp1("tx_idle", 1'b0, serial_tx_out);
        @(posedge mclk);
        #1 io_req = '{wr: 1'b0, rd: 1'b1, target: fru_pkg::FRU_SEL_NONE, wdata: 16'h0000};
        @(posedge mclk);
        #1 io_req = '0;
        cmp1("rack_none", 1'b0, io_rack);
        cmp16("rdata_hold", 16'h0006, io_rdata);
        io_wr(16'ha53c);
        chk_status(8'h04, 8'hff);
        io_wr(16'h00c3);
        chk_status(8'h00, 8'hff);
        io_wr(16'h0011);
        term.send(8'h5a, 1'b0, 1'b0);
        poll_ready();
        chk_status(8'h01, 8'hf1);
        io_rd(fru_pkg::FRU_SEL_RX, rd_val);
        cmp16("rx_data", 16'h005a, rd_val);
        chk_status(8'h00, 8'hf1);
        term.send(8'h81, 1'b1, 1'b0);
        chk_status(8'h91, 8'hf1);
        term.send(8'h3e, 1'b0, 1'b1);
        chk_status(8'he1, 8'hf1);
        io_rd(fru_pkg::FRU_SEL_RX, rd_val);
        cmp16("rx_data", 16'h003e, rd_val);
        chk_status(8'h06, 8'hff);
        cmp16("tx_count", 16'h0002, 16'(term.got_byte.size()));
        cmp16("tx_byte0", 16'h003c, {8'h00, term.got_byte[0]});
        cmp16("tx_byte1", 16'h00c3, {8'h00, term.got_byte[1]});
        cmp1("tx_frame0", 1'b1, term.got_ok[0]);
        cmp1("tx_frame1", 1'b1, term.got_ok[1]);
        cmp1("tx_gap", 1'b1, (term.got_start[1] - term.got_start[0])
             inside {[11 * BIT_CYC - 2 : 11 * BIT_CYC + 2]});
        cmp1("tx_idle_end", 1'b0, serial_tx_out);
        summarize();
    end
endmodule : fru_uart_tb
`default_nettype wire
